// ===== rtl/bsdc_consts.svh
// constants for the battery sense conditioning block
`ifndef BSDC_CONSTS_SVH
`define BSDC_CONSTS_SVH
`define BSDC_CLK_HZ      50000000
`define BSDC_DEC_HZ      512000
`define BSDC_TICK_DIV    (`BSDC_CLK_HZ / `BSDC_DEC_HZ)
`define BSDC_ADR_CTL     7'h00
`define BSDC_ADR_CVCR    7'h04
`define BSDC_ADR_VOFS    7'h08
`define BSDC_ADR_COFS    7'h0C
`define BSDC_ADR_CURR    7'h10
`define BSDC_ADR_VOLT    7'h14
`define BSDC_ADR_ITEMP   7'h18
`define BSDC_ADR_ETEMP   7'h1C
`define BSDC_COEF_BIT    6
`define BSDC_DF_MIN      11'h040
`define BSDC_DEC_MAX     3'h4
`define BSDC_TEMP_DEC    3'h1
`define BSDC_NORM_BIAS   5'h02
`define BSDC_NORM_STEP   5'h03
`define BSDC_CHOP_LAST   2'h3
`define BSDC_OFS_SHIFT   2
`define BSDC_COEF_SHIFT  15
`define BSDC_CUR_MIN     40'shFF_FFFF_0000
`define BSDC_CUR_MAX     40'sh00_0000_FFFF
`define BSDC_U16_MIN     40'sh00_0000_0000
`define BSDC_U16_MAX     40'sh00_0000_FFFF
`define BSDC_TEMP_BIAS   40'sh00_0001_0000
`endif

// ===== rtl/bsdc_pkg.sv
// types shared by the battery sense conditioning block
package bsdc_pkg;
   typedef struct packed {
      logic [6:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } bsdc_avs_t;
   typedef struct packed {
      logic               vld;
      logic signed [17:0] data;
   } bsdc_smp_t;
   typedef struct packed {
      logic cur_en;
      logic volt_en;
      logic itemp_en;
      logic etemp_en;
      logic iir_en;
      logic chop_en;
      logic lp_en;
      logic tchop_en;
      logic ccomp;
      logic vcomp;
      logic cirq_en;
      logic virq_en;
   } bsdc_ctl_t;
   typedef struct packed {
      logic [2:0] gain;
      logic [3:0] taps;
      logic [2:0] dec;
      logic [2:0] alpha;
   } bsdc_cvcr_t;
   typedef enum logic [0:0] {
      BSDC_T_INT = 1'b0,
      BSDC_T_EXT = 1'b1
   } bsdc_tsel_t;
   typedef struct packed {
      logic [33:0] i1, i2, i3, c1, c2, c3;
      logic [9:0]  cnt;
      bsdc_smp_t   smp;
   } bsdc_sinc_st_t;
   typedef struct packed {
      logic [3:0]         s1, s2;
      logic [6:0]         tick_cnt;
      bsdc_ctl_t          ctl;
      bsdc_cvcr_t         cvcr;
      logic [7:0]         vofs;
      logic [7:0][7:0]    cofs;
      logic [15:0][15:0]  coef;
      logic               chop_ph;
      logic [1:0]         chop_cnt;
      logic [17:0]        iir_i, iir_v;
      logic [3:0][17:0]   avg_i, avg_v;
      logic [15:0][17:0]  dl_i, dl_v;
      logic [23:0]        curr;
      logic [15:0]        volt, itemp, etemp;
      bsdc_tsel_t         tsel;
      logic               thalf;
      logic [17:0]        tprev;
      logic               ack, cirq, virq, tcal;
      logic [31:0]        rdata;
   } bsdc_st_t;
endpackage

// ===== rtl/bsdc_sinc3.sv
// third order sinc decimator with selectable factor
`timescale 1ns/1ns
`include "bsdc_consts.svh"
module bsdc_sinc3 import bsdc_pkg::*; (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       tick,
   input  wire logic       clr,
   input  wire logic       bit_in,
   input  wire logic [2:0] sel,
   output bsdc_smp_t       smp
);
   bsdc_sinc_st_t st, nx;
   logic [33:0]   x, d1, d2, d3;
   logic [9:0]    last;
   logic [4:0]    shamt;

   // factor is 64 shifted left by sel
   assign last  = 10'((`BSDC_DF_MIN << sel) - 11'h001);
   assign shamt = 5'(sel) * `BSDC_NORM_STEP + `BSDC_NORM_BIAS;
   assign smp   = st.smp;

   // integrators at tick rate, combs at output rate
   always_comb begin
      nx = st;
      nx.smp.vld = 1'b0;
      x  = bit_in ? 34'h0_0000_0001 : {34{1'b1}};
      d1 = st.i3 - st.c1;
      d2 = d1 - st.c2;
      d3 = d2 - st.c3;
      if (clr) begin
         nx = '0;
      end else if (tick) begin
         nx.i1 = st.i1 + x;
         nx.i2 = st.i2 + st.i1;
         nx.i3 = st.i3 + st.i2;
         if (st.cnt == last) begin
            nx.cnt      = '0;
            nx.c1       = st.i3;
            nx.c2       = d1;
            nx.c3       = d2;
            nx.smp.vld  = 1'b1;
            nx.smp.data = 18'($signed(d3) >>> shamt);
         end else begin
            nx.cnt = st.cnt + 10'h001;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_SINC_TICK: assert property (
      smp.vld |-> $past(tick) && !$past(clr))
      else $error("sample not caused by a tick");
   AST_SINC_SPACE: assert property (
      smp.vld |=> !smp.vld [*8])
      else $error("samples too close together");
endmodule // bsdc_sinc3

// ===== rtl/bsdc_top.sv
// battery sense digital conditioning: current, voltage, temperature
//
// What this block does
// - one voltage offset trim, eight current trims, one per gain
// - current trim window reaches the buffer picked by active gain
// - trims are 8-bit two's complement, reset zero, no correction
// - chopper runs slow, phase spans four decimator outputs
// - iir output is input over 2^alpha plus rest of old output
// - sinc3 decimator, factor by 3-bit field, 0.5 to 8 kS/s
// - four-sample average removes chopper-modulated noise
// - throughput 512 kHz over factor, factor 64 to 1024
// - latency grows with iir, chopper average and tap count
// - 4-bit tap count; clearing low-pass enable bypasses it
// - fir with sixteen 16-bit coefficients shared by both channels
// - fir delay steps at decimator output rate, no extra decimation
// - voltage result 16 bits, current 24 bits with gain inside
// - new result stored and raises request when enabled
// - results saturate: voltage 0..FFFF, current 10000..0FFFF
// - enabling both channels in one write starts them together
// - low power stops voltage channel only; restart to resync
// - temperature decimation fixed 128, chopper adds 2-average
// - both sensors enabled alternate, internal one first
// - temperature 16 bits unsigned, saturates, internal feeds cal
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "bsdc_consts.svh"
module bsdc_top import bsdc_pkg::*; (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire bsdc_avs_t   avs_req,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        mod_cur_bit,
   input  wire logic        mod_volt_bit,
   input  wire logic        mod_temp_bit,
   input  wire logic        low_power_pin,
   output logic             chop_phase_pin,
   output logic             temp_chop_pin,
   output logic             external_temp_supply_pin,
   output logic             current_irq,
   output logic             voltage_irq,
   output logic             cal_request
);
   bsdc_st_t   st, nx;
   bsdc_smp_t  i_smp, v_smp, t_smp;
   logic       tick, req, lp_s, t_done, both_t;
   logic [2:0] dec_sel;
   logic [31:0] rd_mux;

   // synchronised pins and derived strobes
   assign lp_s    = st.s2[0];
   assign tick    = (st.tick_cnt == 7'(`BSDC_TICK_DIV - 1));
   assign req     = avs_req.read | avs_req.write;
   assign dec_sel = (st.cvcr.dec > `BSDC_DEC_MAX) ? `BSDC_DEC_MAX
                                                 : st.cvcr.dec;
   assign both_t  = st.ctl.itemp_en & st.ctl.etemp_en;
   assign t_done  = t_smp.vld & (~st.ctl.tchop_en | st.thalf);

   // bus answer one cycle after the request appears
   assign avs_waitrequest = req & ~st.ack;
   assign avs_readdata    = st.rdata;

   // outputs straight from state
   assign chop_phase_pin  = st.ctl.chop_en & st.chop_ph;
   assign temp_chop_pin   = st.ctl.tchop_en & st.thalf;
   assign external_temp_supply_pin = (st.tsel == BSDC_T_EXT);
   assign current_irq     = st.cirq;
   assign voltage_irq     = st.virq;
   assign cal_request     = st.tcal;

   // current decimator; clear while disabled
   bsdc_sinc3 u_cur (
      .core_clk (core_clk),
      .reset    (reset),
      .tick     (tick),
      .clr      (~st.ctl.cur_en),
      .bit_in   (st.s2[3]),
      .sel      (dec_sel),
      .smp      (i_smp)
   );

   // voltage decimator; held clear in low power
   bsdc_sinc3 u_volt (
      .core_clk (core_clk),
      .reset    (reset),
      .tick     (tick),
      .clr      (~st.ctl.volt_en | lp_s),
      .bit_in   (st.s2[2]),
      .sel      (dec_sel),
      .smp      (v_smp)
   );

   // temperature decimator, factor fixed at 128
   bsdc_sinc3 u_temp (
      .core_clk (core_clk),
      .reset    (reset),
      .tick     (tick),
      .clr      (~(st.ctl.itemp_en | st.ctl.etemp_en)),
      .bit_in   (st.s2[1]),
      .sel      (`BSDC_TEMP_DEC),
      .smp      (t_smp)
   );

   // saturate a wide signed value between two bounds
   function automatic logic signed [39:0] f_sat(
      input logic signed [39:0] v,
      input logic signed [39:0] lo,
      input logic signed [39:0] hi);
      f_sat = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // one channel's trim, iir, average and fir
   task automatic t_chan(
      input  logic signed [17:0] x,
      input  logic [7:0]         ofs,
      input  logic               comp,
      input  logic [17:0]        iq,
      input  logic [3:0][17:0]   aq,
      input  logic [15:0][17:0]  dq,
      output logic [17:0]        id,
      output logic [3:0][17:0]   ad,
      output logic [15:0][17:0]  dd,
      output logic signed [39:0] res);
      logic signed [17:0] xo;
      logic signed [17:0] df;
      logic signed [19:0] sum;
      logic signed [39:0] acc;
      xo  = x;
      df  = '0;
      sum = '0;
      acc = '0;
      if (comp) begin
         xo = x + (18'($signed(ofs)) <<< `BSDC_OFS_SHIFT);
      end
      if (st.ctl.iir_en) begin
         df = xo - $signed(iq);
         id = 18'($signed(iq) + (df >>> st.cvcr.alpha));
      end else begin
         id = xo;
      end
      ad = {aq[2:0], id};
      if (st.ctl.chop_en) begin
         for (int k = 0; k < 4; k++) begin
            sum = sum + 20'($signed(ad[k]));
         end
         sum = sum >>> 2;
      end else begin
         sum = 20'($signed(id));
      end
      dd = {dq[14:0], sum[17:0]};
      if (st.ctl.lp_en) begin
         for (int k = 0; k < 16; k++) begin
            if (k <= int'(st.cvcr.taps)) begin
               acc = acc + 40'($signed(dd[k]) *
                               $signed(st.coef[k]));
            end
         end
         res = acc >>> `BSDC_COEF_SHIFT;
      end else begin
         res = 40'(sum);
      end
   endtask

   // register read selection
   always_comb begin
      rd_mux = '0;
      case (avs_req.address)
         `BSDC_ADR_CTL:   rd_mux = 32'(st.ctl);
         `BSDC_ADR_CVCR:  rd_mux = 32'(st.cvcr);
         `BSDC_ADR_VOFS:  rd_mux = 32'(st.vofs);
         `BSDC_ADR_COFS:  rd_mux = 32'(st.cofs[st.cvcr.gain]);
         `BSDC_ADR_CURR:  rd_mux = 32'(st.curr);
         `BSDC_ADR_VOLT:  rd_mux = 32'(st.volt);
         `BSDC_ADR_ITEMP: rd_mux = 32'(st.itemp);
         `BSDC_ADR_ETEMP: rd_mux = 32'(st.etemp);
         default: begin
            if (avs_req.address[`BSDC_COEF_BIT]) begin
               rd_mux = 32'(st.coef[avs_req.address[5:2]]);
            end
         end
      endcase
   end

   // next state of the whole block
   always_comb begin
      logic signed [17:0] xi, xv, xt;
      logic signed [39:0] ri, rv, rt, sat;
      nx = st;
      xi = '0;
      xv = '0;
      xt = '0;
      ri = '0;
      rv = '0;
      rt = '0;
      sat = '0;
      nx.s1 = {mod_cur_bit, mod_volt_bit, mod_temp_bit, low_power_pin};
      nx.s2 = st.s1;
      nx.tick_cnt = tick ? '0 : st.tick_cnt + 7'h01;
      nx.cirq = 1'b0;
      nx.virq = 1'b0;
      nx.tcal = 1'b0;

      // bus: capture read data, apply write on the answer edge
      nx.ack = req & ~st.ack;
      if (avs_req.read & ~st.ack) begin
         nx.rdata = rd_mux;
      end
      if (avs_req.write & st.ack) begin
         case (avs_req.address)
            `BSDC_ADR_CTL:  nx.ctl  = bsdc_ctl_t'(avs_req.writedata[11:0]);
            `BSDC_ADR_CVCR: nx.cvcr = bsdc_cvcr_t'(avs_req.writedata[12:0]);
            `BSDC_ADR_VOFS: nx.vofs = avs_req.writedata[7:0];
            `BSDC_ADR_COFS: begin
               nx.cofs[st.cvcr.gain] = avs_req.writedata[7:0];
            end
            default: begin
               if (avs_req.address[`BSDC_COEF_BIT]) begin
                  nx.coef[avs_req.address[5:2]] = avs_req.writedata[15:0];
               end
            end
         endcase
      end

      // chopper phase flips every fourth decimator output
      if (!st.ctl.chop_en) begin
         nx.chop_ph  = 1'b0;
         nx.chop_cnt = '0;
      end else if (i_smp.vld | v_smp.vld) begin
         nx.chop_cnt = st.chop_cnt + 2'h1;
         if (st.chop_cnt == `BSDC_CHOP_LAST) begin
            nx.chop_ph = ~st.chop_ph;
         end
      end
      xi = (st.ctl.chop_en & st.chop_ph) ? -i_smp.data : i_smp.data;
      xv = (st.ctl.chop_en & st.chop_ph) ? -v_smp.data : v_smp.data;

      // current path: result carries the active gain
      if (i_smp.vld) begin
         t_chan(xi, st.cofs[st.cvcr.gain], st.ctl.ccomp, st.iir_i,
                st.avg_i, st.dl_i, nx.iir_i, nx.avg_i, nx.dl_i, ri);
         sat = f_sat(ri, `BSDC_CUR_MIN, `BSDC_CUR_MAX);
         nx.curr = {st.cvcr.gain, 4'h0, sat[16:0]};
         nx.cirq = st.ctl.cirq_en;
      end

      // voltage path
      if (v_smp.vld) begin
         t_chan(xv, st.vofs, st.ctl.vcomp, st.iir_v,
                st.avg_v, st.dl_v, nx.iir_v, nx.avg_v, nx.dl_v, rv);
         sat = f_sat(rv, `BSDC_U16_MIN, `BSDC_U16_MAX);
         nx.volt = sat[15:0];
         nx.virq = st.ctl.virq_en;
      end

      // temperature: optional pair average, then sensor alternation
      if (t_smp.vld) begin
         xt = st.thalf ? -t_smp.data : t_smp.data;
         if (st.ctl.tchop_en) begin
            nx.thalf = ~st.thalf;
            nx.tprev = xt;
         end else begin
            nx.thalf = 1'b0;
         end
      end
      if (t_done) begin
         if (st.ctl.tchop_en) begin
            rt = (40'($signed(st.tprev)) + 40'(xt)) >>> 1;
         end else begin
            rt = 40'(xt);
         end
         sat = f_sat((rt + `BSDC_TEMP_BIAS) >>> 1,
                     `BSDC_U16_MIN, `BSDC_U16_MAX);
         case (st.tsel)
            BSDC_T_INT: begin
               if (st.ctl.itemp_en) begin
                  nx.itemp = sat[15:0];
                  nx.tcal  = 1'b1;
               end
               nx.tsel = st.ctl.etemp_en ? BSDC_T_EXT : BSDC_T_INT;
            end
            BSDC_T_EXT: begin
               if (st.ctl.etemp_en) begin
                  nx.etemp = sat[15:0];
               end
               nx.tsel = st.ctl.itemp_en ? BSDC_T_INT : BSDC_T_EXT;
            end
            default: nx.tsel = BSDC_T_INT;
         endcase
      end
      if (!(st.ctl.itemp_en | st.ctl.etemp_en)) begin
         nx.thalf = 1'b0;
         nx.tsel  = BSDC_T_INT;
      end else if (!st.ctl.itemp_en) begin
         nx.tsel = BSDC_T_EXT;
      end else if (!st.ctl.etemp_en) begin
         nx.tsel = BSDC_T_INT;
      end
   end

   // state register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_req_new;
      req && !st.ack;
   endsequence
   sequence s_both_on;
      $rose(st.ctl.cur_en) && $rose(st.ctl.volt_en) && !lp_s;
   endsequence
   sequence s_cofs_wr;
      avs_req.write && st.ack && avs_req.address == `BSDC_ADR_COFS;
   endsequence

   AST_BUS_ONE: assert property (
      s_req_new |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not one cycle after request");
   AST_OFS_WIN: assert property (
      s_cofs_wr |=> st.cofs[$past(st.cvcr.gain)] ==
                    $past(avs_req.writedata[7:0]))
      else $error("current trim window hit wrong buffer");
   AST_CURR_GAIN: assert property (
      $changed(st.curr) |-> st.curr[23:21] == $past(st.cvcr.gain))
      else $error("current result lacks active gain");
   AST_CIRQ: assert property (
      current_irq |-> $past(i_smp.vld) && $past(st.ctl.cirq_en))
      else $error("current request without enabled result");
   AST_VSTOP: assert property (
      lp_s |=> !v_smp.vld)
      else $error("voltage ran in low power");
   AST_SYNC: assert property (
      s_both_on |-> (i_smp.vld == v_smp.vld) [*8])
      else $error("channels started apart");
   AST_TALT: assert property (
      t_done && both_t && st.tsel == BSDC_T_INT |=> st.tsel == BSDC_T_EXT)
      else $error("sensor did not alternate");
   AST_TICK: assert property (
      tick |=> !tick [*8])
      else $error("decimator tick too fast");
   AST_CHOP: assert property (
      $changed(st.chop_ph) |-> $past(i_smp.vld || v_smp.vld) ||
                               !$past(st.ctl.chop_en))
      else $error("chop phase moved off an output");
endmodule // bsdc_top

// ===== bench/bsdc_mod_model.sv
// modulator bit stream model for the three measurement channels
`timescale 1ns/1ns
`include "bsdc_consts.svh"
module bsdc_mod_model (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [8:0] dens_cur,
   input  wire logic [8:0] dens_volt,
   input  wire logic [8:0] dens_temp,
   output logic            mod_cur_bit,
   output logic            mod_volt_bit,
   output logic            mod_temp_bit
);
   logic [6:0] div_reg;
   logic [7:0] acc_c_reg, acc_v_reg, acc_t_reg;
   logic [8:0] sum_c, sum_v, sum_t;
   // first order modulator: ones density is dens/256, 256 gives all ones
   assign sum_c = {1'b0, acc_c_reg} + dens_cur;
   assign sum_v = {1'b0, acc_v_reg} + dens_volt;
   assign sum_t = {1'b0, acc_t_reg} + dens_temp;
   // bits step at the modulator rate, held in between
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_reg      <= 7'h00;
         acc_c_reg    <= 8'h00;
         acc_v_reg    <= 8'h00;
         acc_t_reg    <= 8'h00;
         mod_cur_bit  <= 1'b0;
         mod_volt_bit <= 1'b0;
         mod_temp_bit <= 1'b0;
      end else begin
         if (div_reg == 7'(`BSDC_TICK_DIV - 1)) div_reg <= 7'h00;
         else div_reg <= div_reg + 7'h01;
         if (div_reg == 7'h00) begin
            acc_c_reg    <= sum_c[7:0];
            acc_v_reg    <= sum_v[7:0];
            acc_t_reg    <= sum_t[7:0];
            mod_cur_bit  <= sum_c[8];
            mod_volt_bit <= sum_v[8];
            mod_temp_bit <= sum_t[8];
         end
      end
   end
endmodule // bsdc_mod_model

// ===== bench/bsdc_bench.sv
// self-checking bench for the battery sense conditioning block
`timescale 1ns/1ns
`include "bsdc_consts.svh"
module bsdc_bench import bsdc_pkg::*;;
   localparam int PER  = `BSDC_TICK_DIV * 64;
   localparam int TPER = 2 * 128 * `BSDC_TICK_DIV;
   logic        core_clk, reset, low_power_pin, wait_s, ext_q;
   bsdc_avs_t   avs_req;
   logic [31:0] avs_readdata, rnd;
   logic        avs_waitrequest, chop_phase_pin, temp_chop_pin;
   logic        external_temp_supply_pin, current_irq, voltage_irq;
   logic        cal_request, mod_cur_bit, mod_volt_bit, mod_temp_bit;
   logic [8:0]  dens_cur, dens_volt, dens_temp;
   logic [31:0] expq[$];
   logic [7:0]  trim[8];
   logic [15:0] coef[16];
   int          errors, n_tests, cyc, last_v, last_c, nv, ni, nc, np;
   int          v0, i0;

   bsdc_top uut (
      .core_clk                 (core_clk),
      .reset                    (reset),
      .avs_req                  (avs_req),
      .avs_readdata             (avs_readdata),
      .avs_waitrequest          (avs_waitrequest),
      .mod_cur_bit              (mod_cur_bit),
      .mod_volt_bit             (mod_volt_bit),
      .mod_temp_bit             (mod_temp_bit),
      .low_power_pin            (low_power_pin),
      .chop_phase_pin           (chop_phase_pin),
      .temp_chop_pin            (temp_chop_pin),
      .external_temp_supply_pin (external_temp_supply_pin),
      .current_irq              (current_irq),
      .voltage_irq              (voltage_irq),
      .cal_request              (cal_request)
   );
   bsdc_mod_model mod_src (
      .core_clk     (core_clk),
      .reset        (reset),
      .dens_cur     (dens_cur),
      .dens_volt    (dens_volt),
      .dens_temp    (dens_temp),
      .mod_cur_bit  (mod_cur_bit),
      .mod_volt_bit (mod_volt_bit),
      .mod_temp_bit (mod_temp_bit)
   );

   // clock generator
   always #10 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one bus access; entered right after a rising edge
   task automatic bus(input logic is_rd, input logic [6:0] a,
                      input logic [31:0] d, input logic [31:0] e);
      avs_req.address   <= a;
      avs_req.read      <= is_rd;
      avs_req.write     <= ~is_rd;
      avs_req.writedata <= d;
      if (is_rd) expq.push_back(e);
      do @(posedge core_clk); while (wait_s !== 1'b0);
      avs_req.read  <= 1'b0;
      avs_req.write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 32'h0);
   endtask

   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0, e);
   endtask

   // cycle counter
   always @(posedge core_clk) cyc <= cyc + 1;

   // output watcher: read data against the oldest note, result events
   always @(negedge core_clk) begin
      wait_s = avs_waitrequest;
      if (avs_req.read && avs_waitrequest === 1'b0) begin
         if (expq.size() == 0) check("read note", 32'h1, 32'h0);
         else check("readdata", expq.pop_front(), avs_readdata);
      end
      if (voltage_irq === 1'b1) begin
         check("irq pairing", 32'h1, {31'h0, current_irq});
         if (last_v > 0) check("volt period", PER, cyc - last_v);
         last_v = cyc;
         nv++;
      end
      if (current_irq === 1'b1) ni++;
      if (cal_request === 1'b1) begin
         if (last_c > 0) check("temp period", TPER, cyc - last_c);
         last_c = cyc;
         nc++;
      end
      if (external_temp_supply_pin === 1'b1 && ext_q !== 1'b1) np++;
      ext_q = external_temp_supply_pin;
   end

   // watchdog, a little beyond the longest expected run
   initial begin
      repeat (3 * TPER + 3 * PER) @(posedge core_clk);
      errors++;
      $display("watchdog expired");
      close_out;
   end

   // main sequence
   initial begin
      core_clk      = 1'b0;
      reset         = 1'b1;
      avs_req       = '0;
      low_power_pin = 1'b0;
      dens_cur      = 9'h000;
      dens_volt     = 9'h100;
      dens_temp     = 9'h100;
      rnd           = 32'h0000EFC8;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      // reset values, read-only current result and an unmapped place
      for (int i = 0; i < 8; i++) rd(7'(4 * i), 32'h0);
      wr(`BSDC_ADR_CURR, 32'h0000FFFF);
      rd(`BSDC_ADR_CURR, 32'h0);
      wr(7'h24, 32'h0000005A);
      rd(7'h24, 32'h0);
      $display("test reset_map done");
      // trim extremes, then one trim per gain with random upper bits
      wr(`BSDC_ADR_VOFS, 32'hFFFFFF80);
      rd(`BSDC_ADR_VOFS, 32'h00000080);
      wr(`BSDC_ADR_VOFS, 32'h0000007F);
      rd(`BSDC_ADR_VOFS, 32'h0000007F);
      for (int g = 0; g < 8; g++) begin
         rnd = xs(rnd);
         trim[g] = rnd[7:0];
         wr(`BSDC_ADR_CVCR, 32'(g) << 10);
         wr(`BSDC_ADR_COFS, rnd);
      end
      for (int g = 0; g < 8; g++) begin
         wr(`BSDC_ADR_CVCR, 32'(g) << 10);
         rd(`BSDC_ADR_COFS, {24'h0, trim[g]});
      end
      rd(`BSDC_ADR_VOFS, 32'h0000007F);
      $display("test trims done");
      // shared coefficient set
      for (int i = 0; i < 16; i++) begin
         rnd = xs(rnd);
         coef[i] = rnd[15:0];
         wr(7'(7'h40 + 4 * i), rnd);
      end
      for (int i = 0; i < 16; i++)
         rd(7'(7'h40 + 4 * i), {16'h0, coef[i]});
      $display("test coefficients done");
      // gain 5, fastest decimation, all channels enabled in one write
      wr(`BSDC_ADR_CVCR, 32'h00001400);
      wr(`BSDC_ADR_VOFS, 32'h00000000);
      wr(`BSDC_ADR_CTL, 32'h00000F03);
      repeat (4) @(posedge core_clk);
      check("sensor start", 32'h0, {31'h0, external_temp_supply_pin});
      while (nc < 3) @(posedge core_clk);
      rd(`BSDC_ADR_CURR, 32'h00A10000);
      rd(`BSDC_ADR_VOLT, 32'h0000FFFF);
      rd(`BSDC_ADR_ITEMP, 32'h0000FFFF);
      rd(`BSDC_ADR_ETEMP, 32'h0000FFFF);
      check("sensor turns", 32'h1, {31'h0, np >= 2});
      check("chop idle", 32'h0, {31'h0, chop_phase_pin});
      $display("test conversion done");
      // iir at half step, +0x40 trim, one low-pass tap of one half
      wr(7'h40, 32'h00004000);
      wr(`BSDC_ADR_VOFS, 32'h00000010);
      wr(`BSDC_ADR_CVCR, 32'h00001401);
      wr(`BSDC_ADR_CTL, 32'h00000CA7);
      v0 = nv;
      while (nv == v0) @(posedge core_clk);
      rd(`BSDC_ADR_VOLT, 32'h00008010);
      rd(`BSDC_ADR_CURR, 32'h00A18000);
      $display("test lowpass done");
      // low power stops only the voltage channel
      low_power_pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      v0 = nv;
      i0 = ni;
      repeat (3 * PER) @(posedge core_clk);
      check("volt in low power", 32'(v0), 32'(nv));
      check("cur in low power", 32'h1, {31'h0, ni - i0 >= 2});
      $display("test low_power done");
      close_out;
   end
endmodule // bsdc_bench
